// ### verilog/charger_host_pkg.sv
// shared constants, types and register map of the charger host port
package charger_host_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ = 40;
    localparam int PULSE_US = 128;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int RB_HOLD_MS = 1;
    localparam int RB_HOLD_CYC = RB_HOLD_MS * 1000 * CLK_MHZ;

    // ****************************************
    // two-wire slave port
    // ****************************************
    localparam logic [6:0] SLAVE_ADDR = 7'h6B;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] READ_FILL = 8'hFF;
    localparam int NREG_DEF = 3;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_VREG = 8'h01;
    localparam logic [7:0] REG_STAT = 8'h02;

    // ****************************************
    // local register port (byte addresses)
    // ****************************************
    localparam logic [3:0] LOC_CTRL = 4'h0;
    localparam logic [3:0] LOC_VREG = 4'h4;
    localparam logic [3:0] LOC_STAT = 4'h8;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int CTRL_W = 2;
    localparam int CTRL_STAT_EN = 0;
    localparam int CTRL_NOBAT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int VREG_W = 6;
    localparam logic [5:0] VREG_DEFAULT = 6'h05;
    localparam int MV_W = 13;
    localparam logic [12:0] VREG_BASE_MV = 13'hDAC;
    localparam logic [12:0] VREG_STEP_MV = 13'h014;
    localparam logic [19:0] TZ_NUM = 20'h00062;
    localparam logic [19:0] TZ_DEN = 20'h00064;
    localparam int EVT_N = 7;
    localparam logic [6:0] EVT_BOTH_EDGES = 7'h01;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_DACK, ST_TX, ST_TACK} i2c_state_t;
    typedef enum logic [1:0] {RB_IDLE, RB_HOLD, RB_TEST, RB_WAIT} rb_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic chg_active;
        logic host_mode;
        logic bat_above_good;
        logic rev_current;
        logic supplement_trip;
        logic bat_below_ovp;
        logic bat_above_recharge;
        logic bat_above_reg;
    } sense_t;

endpackage

// ### verilog/charger_host_port.sv
// two-wire slave, status/interrupt pins and reverse boost control of the charger
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
// Operation
// R1 - answer only 7-bit address 6Bh, ignore all other addresses
// R2 - work at 100k and 400k bit rates with one protocol
// R3 - falling data while clock high starts address reception
// R4 - data changes only while clock low, except start and stop
// R5 - matching address acked low through whole ninth clock high phase
// R6 - bytes of eight bits plus receiver ack, repeating without limit
// R7 - rising data while clock high releases bus and returns idle
// R8 - master sends stop after abandoning a transfer to reset the slave
// R9 - reads of unimplemented register addresses return FFh
// R10 - direction bit zero is master write, one is master read
// R11 - status pin low while charging when status enable set
// R12 - status pin high impedance otherwise
// R13 - each event gives one 128 us low pulse, then release
// R14 - supply, timer, watchdog, sleep, temperature, battery, thermal events pulse
// R15 - pulses ignore the status enable bit
// R16 - interrupt pin copies status pin exactly
// R17 - in default mode good battery forces high impedance mode
// R18 - reverse current opens switch 1 ms, then reclose and retest
// R19 - reverse protection armed only between overvoltage and recharge levels
// R20 - reverse boost stops charging until battery below recharge level
// R21 - no battery operation bit disables reverse boost prevention
// R22 - leaving host mode reloads regulation voltage default 3.6 V
// R23 - temperature zone parts scale reference to 0.98 of regulation
module charger_host_port import charger_host_pkg::*; #(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int RB_CYCLES = RB_HOLD_CYC,
    parameter int NREG = NREG_DEF,
    parameter logic TEMP_ZONE = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // local register port
    input wire bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // analog sense and events
    input wire sense_t sense,
    input wire logic [EVT_N-1:0] evt_i,
    // status and interrupt pins
    output logic stat_o,
    output logic stat_oe,
    output logic int_o,
    output logic int_oe,
    // power stage control
    output logic hiz_force,
    output logic switch_open,
    output logic fb_sys_sel,
    output logic charge_hold,
    output logic [MV_W-1:0] vref_mv
);

    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam int RW = $clog2(RB_CYCLES + 1);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic [EVT_N-1:0] evt_s1, evt_s2, evt_d;
    sense_t sense_s1, sense_s2;
    logic host_d;

    // two stages for every pin, a third stage feeds edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            evt_s1 <= '0;
            evt_s2 <= '0;
            evt_d <= '0;
            sense_s1 <= '0;
            sense_s2 <= '0;
            host_d <= 1'b0;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            evt_s1 <= evt_i;
            evt_s2 <= evt_s1;
            evt_d <= evt_s2;
            sense_s1 <= sense;
            sense_s2 <= sense_s1;
            host_d <= sense_s2.host_mode;
        end
    end

    logic scl_rise, scl_fall, start_evt, stop_evt, host_fell, evt_hit;
    assign scl_rise = scl_s2 & ~scl_d; // [R2]
    assign scl_fall = scl_d & ~scl_s2;
    assign start_evt = scl_s2 & scl_d & sda_d & ~sda_s2; // [R3]
    assign stop_evt = scl_s2 & scl_d & ~sda_d & sda_s2; // [R7]
    assign host_fell = host_d & ~sense_s2.host_mode;
    // supply change pulses on both edges, faults on their onset only
    assign evt_hit = |((evt_s2 & ~evt_d) | ((evt_s2 ^ evt_d) & EVT_BOTH_EDGES)); // [R14]

    // ****************************************
    // register file
    // ****************************************
    logic [CTRL_W-1:0] ctrl_r;
    logic [VREG_W-1:0] vreg_r;
    logic [7:0] stat_byte;
    logic i2c_wr_r;
    logic [7:0] i2c_wa_r, i2c_wd_r;
    logic pulse_on, stat_oe_r, hiz_r, switch_open_r, charge_hold_r;

    assign stat_byte = {3'h0, pulse_on, stat_oe_r, hiz_r, switch_open_r, charge_hold_r};

    function automatic logic [7:0] reg_read(input logic [7:0] idx);
        case (idx)
            REG_CTRL: reg_read = {{(8 - CTRL_W){1'b0}}, ctrl_r};
            REG_VREG: reg_read = {{(8 - VREG_W){1'b0}}, vreg_r};
            REG_STAT: reg_read = stat_byte;
            default: reg_read = READ_FILL; // [R9]
        endcase
    endfunction

    // local port writes follow the serial ones so they win a same-cycle clash
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            vreg_r <= VREG_DEFAULT;
        end else begin
            if (i2c_wr_r && i2c_wa_r == REG_CTRL) begin
                ctrl_r <= i2c_wd_r[CTRL_W-1:0];
            end
            if (i2c_wr_r && i2c_wa_r == REG_VREG) begin
                vreg_r <= i2c_wd_r[VREG_W-1:0];
            end
            if (bus_req.wr && bus_req.addr == LOC_CTRL) begin
                ctrl_r <= bus_req.wdata[CTRL_W-1:0];
            end
            if (bus_req.wr && bus_req.addr == LOC_VREG) begin
                vreg_r <= bus_req.wdata[VREG_W-1:0];
            end
            if (host_fell) begin
                vreg_r <= VREG_DEFAULT; // [R22]
            end
        end
    end

    // local read data valid in the cycle after the strobe only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                LOC_CTRL: bus_rdata <= reg_read(REG_CTRL);
                LOC_VREG: bus_rdata <= reg_read(REG_VREG);
                LOC_STAT: bus_rdata <= reg_read(REG_STAT);
                default: bus_rdata <= READ_FILL;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // ****************************************
    // two-wire slave
    // ****************************************
    i2c_state_t st_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] sr_r, tx_r, ptr_r, rd_byte;
    logic rw_r, have_ptr_r, sda_oe_r;

    // a process, not an assign, so register updates behind the function are seen too
    always_comb rd_byte = reg_read(ptr_r);

    // sampling on clock rise and driving on clock fall keeps data still while high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            sr_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            have_ptr_r <= 1'b0;
            sda_oe_r <= 1'b0;
            i2c_wr_r <= 1'b0;
            i2c_wa_r <= 8'h00;
            i2c_wd_r <= 8'h00;
        end else begin
            i2c_wr_r <= 1'b0;
            if (start_evt) begin
                st_r <= ST_ADDR; // [R3]
                bit_cnt_r <= 4'h0;
                have_ptr_r <= 1'b0;
                sda_oe_r <= 1'b0;
            end else if (stop_evt) begin
                st_r <= ST_IDLE; // [R7] [R8]
                sda_oe_r <= 1'b0;
            end else begin
                case (st_r)
                    ST_IDLE: begin
                        sda_oe_r <= 1'b0;
                    end
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            sr_r <= {sr_r[6:0], sda_s2};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                            if (st_r == ST_RX) begin
                                st_r <= ST_DACK; // [R6]
                                sda_oe_r <= 1'b1;
                                i2c_wr_r <= have_ptr_r;
                                i2c_wa_r <= ptr_r;
                                i2c_wd_r <= sr_r;
                                ptr_r <= have_ptr_r ? ptr_r + 8'h01 : sr_r;
                                have_ptr_r <= 1'b1;
                            end else if (sr_r[7:1] == SLAVE_ADDR) begin
                                st_r <= ST_AACK; // [R1] [R5]
                                sda_oe_r <= 1'b1;
                                rw_r <= sr_r[0]; // [R10]
                            end else begin
                                st_r <= ST_IDLE; // [R1]
                            end
                        end
                    end
                    ST_AACK, ST_DACK, ST_TACK: begin
                        if (scl_rise && st_r == ST_TACK) begin
                            sr_r <= {sr_r[6:0], sda_s2};
                        end else if (scl_fall) begin
                            bit_cnt_r <= 4'h0;
                            if ((st_r == ST_AACK && rw_r) || (st_r == ST_TACK && !sr_r[0])) begin
                                st_r <= ST_TX; // [R10] [R6]
                                tx_r <= rd_byte;
                                sda_oe_r <= ~rd_byte[7];
                                ptr_r <= ptr_r + 8'h01;
                            end else if (st_r == ST_TACK) begin
                                st_r <= ST_IDLE;
                                sda_oe_r <= 1'b0;
                            end else begin
                                st_r <= ST_RX;
                                sda_oe_r <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_r == BITS_PER_BYTE) begin
                                st_r <= ST_TACK;
                                sda_oe_r <= 1'b0;
                            end else begin
                                tx_r <= {tx_r[6:0], 1'b0};
                                sda_oe_r <= ~tx_r[6]; // [R4]
                            end
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_r;

    // ****************************************
    // status and interrupt pins
    // ****************************************
    logic [PW-1:0] pulse_cnt_r;
    assign pulse_on = pulse_cnt_r != '0;

    // a new event restarts the pulse rather than queueing a second one
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt_r <= '0;
        end else if (evt_hit) begin
            pulse_cnt_r <= PW'(PULSE_CYCLES); // [R13]
        end else if (pulse_on) begin
            pulse_cnt_r <= pulse_cnt_r - PW'(1);
        end
    end

    logic int_oe_r;
    // pins are open drain: enable high pulls the line low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_oe_r <= 1'b0;
            int_oe_r <= 1'b0;
        end else begin
            stat_oe_r <= (sense_s2.chg_active & ctrl_r[CTRL_STAT_EN]) | pulse_on; // [R11] [R12] [R15]
            int_oe_r <= (sense_s2.chg_active & ctrl_r[CTRL_STAT_EN]) | pulse_on; // [R16]
        end
    end

    assign stat_o = 1'b0;
    assign int_o = 1'b0;
    assign stat_oe = stat_oe_r;
    assign int_oe = int_oe_r;

    // ****************************************
    // good battery and reverse boost control
    // ****************************************
    rb_state_t rb_st;
    logic [RW-1:0] rb_cnt_r;
    logic rb_armed, no_bat;
    assign no_bat = ctrl_r[CTRL_NOBAT];
    assign rb_armed = sense_s2.bat_below_ovp & sense_s2.bat_above_recharge & ~no_bat; // [R19] [R21]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rb_st <= RB_IDLE;
            rb_cnt_r <= '0;
        end else if (no_bat) begin
            rb_st <= RB_IDLE; // [R21]
            rb_cnt_r <= '0;
        end else begin
            case (rb_st)
                RB_IDLE: begin
                    if (rb_armed && sense_s2.rev_current && !sense_s2.supplement_trip) begin
                        rb_st <= RB_HOLD; // [R18]
                        rb_cnt_r <= '0;
                    end
                end
                RB_HOLD: begin
                    if (rb_cnt_r == RW'(RB_CYCLES - 1)) begin
                        rb_st <= RB_TEST; // [R18]
                    end else begin
                        rb_cnt_r <= rb_cnt_r + RW'(1);
                    end
                end
                RB_TEST: begin
                    rb_cnt_r <= '0;
                    rb_st <= (sense_s2.bat_above_reg && rb_armed) ? RB_HOLD : RB_WAIT; // [R18]
                end
                RB_WAIT: begin
                    if (!sense_s2.bat_above_recharge) begin
                        rb_st <= RB_IDLE; // [R20]
                    end
                end
                default: rb_st <= RB_IDLE;
            endcase
        end
    end

    // reference in millivolts; scaling drops fractions, so it errs low
    logic [19:0] mv_full;
    assign mv_full = 20'(VREG_BASE_MV + VREG_STEP_MV * MV_W'(vreg_r));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hiz_r <= 1'b0;
            switch_open_r <= 1'b0;
            charge_hold_r <= 1'b0;
            vref_mv <= VREG_BASE_MV;
        end else begin
            hiz_r <= ~sense_s2.host_mode & sense_s2.bat_above_good; // [R17]
            switch_open_r <= rb_st == RB_HOLD; // [R18]
            charge_hold_r <= rb_st != RB_IDLE; // [R20]
            vref_mv <= TEMP_ZONE ? MV_W'((mv_full * TZ_NUM) / TZ_DEN) : mv_full[MV_W-1:0]; // [R23]
        end
    end

    assign hiz_force = hiz_r;
    assign switch_open = switch_open_r;
    assign fb_sys_sel = switch_open_r;
    assign charge_hold = charge_hold_r;

    // ****************************************
    // assertions
    // ****************************************
    int pw_len, hold_len;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pw_len <= 0;
            hold_len <= 0;
        end else begin
            pw_len <= evt_hit ? 0 : (pulse_on ? pw_len + 1 : 0);
            hold_len <= switch_open_r ? hold_len + 1 : 0;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    addr_match_a: assert property (st_r == ST_AACK |-> sr_r[7:1] == SLAVE_ADDR) else $error("ack on foreign address"); // [R1] [R5]
    start_entry_a: assert property (start_evt |=> st_r == ST_ADDR && bit_cnt_r == 4'h0) else $error("start missed"); // [R3]
    stop_release_a: assert property (stop_evt |=> st_r == ST_IDLE && !sda_oe) else $error("stop ignored"); // [R7]
    sda_low_phase_a: assert property ($changed(sda_oe_r) && !$past(stop_evt) && !$past(start_evt) |-> $past(scl_fall))
        else $error("data moved outside clock low"); // [R4]
    unmapped_fill_a: assert property (st_r == ST_TX && $past(st_r) != ST_TX && $past(ptr_r) >= NREG |-> tx_r == READ_FILL)
        else $error("unmapped read not FFh"); // [R9]
    pulse_width_a: assert property ($fell(pulse_on) |-> pw_len == PULSE_CYCLES) else $error("pulse width wrong"); // [R13]
    pulse_ungated_a: assert property (pulse_on |=> stat_oe) else $error("pulse gated off"); // [R15]
    pins_equal_a: assert property (stat_oe == int_oe) else $error("pins differ"); // [R16]
    goodbat_hiz_a: assert property (!sense_s2.host_mode && sense_s2.bat_above_good |=> hiz_force)
        else $error("good battery not forcing hiz"); // [R17]
    hold_time_a: assert property ($fell(switch_open_r) |-> $past(hold_len) == RB_CYCLES - 1 || $past(no_bat))
        else $error("switch hold wrong"); // [R18]
    rb_unarmed_a: assert property (rb_st == RB_IDLE && !rb_armed |=> rb_st == RB_IDLE) else $error("unarmed entry"); // [R19]
    vreg_reload_a: assert property (host_fell |=> vreg_r == VREG_DEFAULT) else $error("no reload"); // [R22]

    write_seen_c: cover property (i2c_wr_r);
    read_seen_c: cover property (st_r == ST_TACK ##1 st_r == ST_TX);
    pulse_seen_c: cover property ($fell(pulse_on));
    rb_cycle_c: cover property (rb_st == RB_TEST ##1 rb_st == RB_WAIT);

endmodule

// ### sim/host_master.sv
// two-wire bus master model that drives the charger slave port
`timescale 1ns/100ps
module host_master (
    // clock
    input wire logic mclk,
    // bus pins
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ****************************************
    // bus idle and bit timing
    // ****************************************
    // bus idles released, clock parked high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // 5 low and 3 high mclk: 200 ns per bit, long low phase leaves the slave time to turn sda
    task automatic bit_x(input logic b, output logic r);
        @(posedge mclk);
        sda_low <= !b;
        repeat (4) @(posedge mclk);
        scl <= 1'b1;
        repeat (3) @(posedge mclk);
        r = sda;
        scl <= 1'b0;
    endtask

    // data falls while clock high; doubles as repeated start
    task automatic start_c();
        @(posedge mclk);
        sda_low <= 1'b0;
        repeat (4) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        sda_low <= 1'b1;
        repeat (4) @(posedge mclk);
        scl <= 1'b0;
    endtask

    // data rises while clock high; also ends an abandoned transfer
    task automatic stop_c();
        @(posedge mclk);
        sda_low <= 1'b1;
        repeat (4) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        sda_low <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    // eight bits msb first, then the receiver's bit; address byte carries direction in bit 0
    task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(ack_in, ack);
    endtask
endmodule

// ### sim/testbench.sv
// self-checking bench of the charger host port
`timescale 1ns/100ps
module testbench import charger_host_pkg::*;;
    // ****************************************
    // signals
    // ****************************************
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    bus_req_t bus_req = '0;
    sense_t sense = '0;
    logic [EVT_N-1:0] evt_i = '0;
    logic [7:0] bus_rdata, q, d;
    logic sda_o, sda_oe, stat_o, stat_oe, int_o, int_oe, scl, sda_low, ack;
    logic hiz_force, switch_open, fb_sys_sel, charge_hold;
    logic [MV_W-1:0] vref_mv;
    wire sda = !(sda_low || sda_oe); // pulled up unless someone pulls low
    int failures = 0;
    int total_checks = 0;
    int n, m;
    logic [3:0] la [3] = '{4'h0, 4'h4, 4'hC};
    logic [7:0] lv [3] = '{8'h01, 8'h05, 8'hFF};
    logic [7:0] bad_a [3] = '{8'hD4, 8'hD2, 8'h56};
    logic [7:0] rb_s [5] = '{8'h56, 8'h52, 8'h54, 8'h5E, 8'h56};
    logic [7:0] rb_c [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
    int rb_n [5] = '{30, 0, 0, 0, 0};

    always #12.5 mclk = ~mclk;

    // short pulse and hold counts keep the run brief
    charger_host_port #(.PULSE_CYCLES(20), .RB_CYCLES(30)) charger_host_port_inst (
        .mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .sense(sense), .evt_i(evt_i), .stat_o(stat_o), .stat_oe(stat_oe),
        .int_o(int_o), .int_oe(int_oe), .hiz_force(hiz_force), .switch_open(switch_open),
        .fb_sys_sel(fb_sys_sel), .charge_hold(charge_hold), .vref_mv(vref_mv));
    host_master host_master_inst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [15:0] exp_mv(input logic [7:0] code);
        return 16'(3500 + 20 * code);
    endfunction
    task automatic lw(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge mclk);
        bus_req <= '0;
    endtask
    // read data are sampled at the edge closing the cycle after the strobe
    task automatic lr(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
        v = bus_rdata;
    endtask
    // counts cycles with stat pin pulled low or switch open; tallies pin splits, feedback split and pin drive values
    task automatic cnt(input int k, input logic sel, output int c);
        c = 0;
        repeat (k) begin
            @(posedge mclk);
            c += int'((sel ? switch_open : stat_oe) === 1'b1);
            m += int'(int_oe !== stat_oe);
            m += int'(fb_sys_sel !== switch_open || {sda_o, stat_o, int_o} !== 3'h0);
        end
    endtask
    task automatic xb(input logic [7:0] v, input logic a);
        host_master_inst.byte_x(v, a, q, ack);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        d = 8'($urandom(36));
        m = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        foreach (la[i]) begin
            lr(la[i], q);
            chk(16'(q), 16'(lv[i]));
        end
        chk(16'(vref_mv), 16'd3600);
        // abandoned transfer, then wrong addresses stay unanswered
        host_master_inst.start_c();
        host_master_inst.bit_x(1'b1, ack);
        host_master_inst.stop_c();
        foreach (bad_a[i]) begin
            host_master_inst.start_c();
            xb(bad_a[i], 1'b1);
            chk(16'(ack), 16'h0001);
            host_master_inst.stop_c();
        end
        // serial write of a random regulation code
        d = 8'($urandom_range(6, 63));
        host_master_inst.start_c();
        foreach (lv[i]) begin
            xb(i == 0 ? 8'hD6 : (i == 1 ? REG_VREG : d), 1'b1);
            chk(16'(ack), 16'h0000);
        end
        host_master_inst.stop_c();
        lr(LOC_VREG, q);
        chk(16'(q), 16'(d));
        chk(16'(vref_mv), exp_mv(d));
        // pointer, repeated start, read across the end of the map
        host_master_inst.start_c();
        xb(8'hD6, 1'b1);
        xb(REG_VREG, 1'b1);
        host_master_inst.start_c();
        xb(8'hD7, 1'b1);
        chk(16'(ack), 16'h0000);
        xb(8'hFF, 1'b0);
        chk(16'(q), 16'(d));
        xb(8'hFF, 1'b0);
        chk(16'(q), 16'h0000);
        xb(8'hFF, 1'b1);
        chk(16'(q), 16'h00FF);
        host_master_inst.stop_c();
        // charging level gated by the enable bit
        sense.chg_active <= 1'b1;
        cnt(8, 1'b0, n);
        cnt(10, 1'b0, n);
        chk(16'(n), 16'd10);
        lw(LOC_CTRL, 8'h00);
        cnt(8, 1'b0, n);
        cnt(10, 1'b0, n);
        chk(16'(n), 16'd0);
        sense.chg_active <= 1'b0;
        // every event pulses with the enable bit cleared; supply pulses on both edges
        for (int i = 0; i < EVT_N; i++) begin
            evt_i[i] <= 1'b1;
            cnt(40, 1'b0, n);
            chk(16'(n), 16'd20);
            evt_i[i] <= 1'b0;
            cnt(40, 1'b0, n);
            chk(16'(n), i == 0 ? 16'd20 : 16'd0);
        end
        chk(16'(m), 16'd0);
        // reverse boost: armed band, supplement trip, no battery operation
        foreach (rb_s[i]) begin
            lw(LOC_CTRL, rb_c[i]);
            sense <= sense_t'(rb_s[i]);
            cnt(50, 1'b1, n);
            chk(16'(n), 16'(rb_n[i]));
            chk(16'(charge_hold), 16'(rb_n[i] != 0));
            sense <= sense_t'(8'h40);
            cnt(6, 1'b1, n);
            chk(16'(charge_hold), 16'h0000);
        end
        // good battery only matters in default mode; leaving host mode reloads the code
        sense <= sense_t'(8'h60);
        lw(LOC_VREG, 8'($urandom_range(6, 63)));
        cnt(6, 1'b1, n);
        chk(16'(hiz_force), 16'h0000);
        sense <= sense_t'(8'h20);
        cnt(6, 1'b1, n);
        chk(16'(hiz_force), 16'h0001);
        lr(LOC_VREG, q);
        chk(16'(q), 16'h0005);
        chk(16'(vref_mv), 16'd3600);
        chk(16'(m), 16'd0);
        close_out();
    end

    // hang guard far beyond the expected run length
    initial begin
        #2000000;
        failures++;
        close_out();
    end
endmodule
